// ### aps_machine.sv
`timescale 1ns/1ps
`default_nettype none
// Machine side: encoder turned by the load, one quadrature edge per step request
module aps_machine (
    input wire logic clk,
    input wire logic rstn,
    input wire logic stepFwd,
    input wire logic stepRev,
    output logic encA,
    output logic encB,
    output logic encZ
);
    logic [1:0] phaseQ;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phaseQ <= 2'h0;
        end else if (stepFwd) begin
            phaseQ <= phaseQ + 2'h1;
        end else if (stepRev) begin
            phaseQ <= phaseQ - 2'h1;
        end
    end
    // Channel A leads B when moving forward
    assign encA = phaseQ[1] ^ phaseQ[0];
    assign encB = phaseQ[1];
    assign encZ = 1'b0;
endmodule // aps_machine
`default_nettype wire

// ### aps_pkg.sv
package aps_pkg;
    localparam int APS_PW = 32;
    localparam logic [6:0] FN_TEACH = 7'h2D;
    localparam logic [6:0] FN_SERVO = 7'h36;
    localparam logic [6:0] FN_EXCITE = 7'h37;
    localparam logic [6:0] FN_FWDSTOP = 7'h47;
    localparam logic [6:0] FN_REVSTOP = 7'h48;
    localparam logic [6:0] FN_SPDPOS = 7'h49;
    localparam logic [1:0] HM_LOW = 2'h0;
    localparam logic [1:0] HM_HIGH1 = 2'h1;
    localparam logic [1:0] HM_HIGH2 = 2'h2;
    localparam logic [1:0] CM_ABS = 2'h2;
    localparam logic [1:0] CM_HABS = 2'h3;
    localparam logic [2:0] CC_SENSOR = 3'h5;
    localparam logic [7:0] TORQUE_FULL = 8'h64;
    localparam logic [7:0] TORQUE_STOP = 8'h0A;
    // Register map (APB byte addresses)
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_ASSIGN = 8'h04;
    localparam logic [7:0] A_FWDLIM = 8'h08;
    localparam logic [7:0] A_REVLIM = 8'h0C;
    localparam logic [7:0] A_PULSE = 8'h10;
    localparam logic [7:0] A_PBIAS = 8'h14;
    localparam logic [7:0] A_STATUS = 8'h18;
    localparam logic [7:0] A_POS = 8'h1C;
    localparam logic [7:0] A_PFREQ = 8'h20;
    localparam logic [7:0] A_SLOT0 = 8'h40;
    localparam logic [31:0] FWDLIM_RST = 32'h0FFFFFFF;
    localparam logic [31:0] REVLIM_RST = 32'hF0000001;
    localparam logic [15:0] SCALE_RST = 16'h00FA;
    localparam logic [15:0] TC_RST = 16'h000A;
    localparam logic [7:0] PLIM_RST = 8'h64;
    localparam logic [15:0] FMAX_PCT100 = 16'h2710;
    localparam int GATE_MS = 10;
    localparam int CLK_HZ = 20000000;
    localparam int GATE_CYC = CLK_HZ / 1000 * GATE_MS;
    typedef enum logic [6:0] {
        HS_IDLE = 7'h01, HS_FAST = 7'h02, HS_DECEL = 7'h04, HS_REVLOW = 7'h08,
        HS_DECEL2 = 7'h10, HS_FWDLOW = 7'h20, HS_INDEX = 7'h40
    } aps_home_t;
    typedef struct packed {
        logic run;
        logic dirRev;
        logic [1:0] speed;
        logic coast;
    } aps_drive_t;
endpackage

// ### aps_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
module aps_supervisor
    import aps_pkg::*;
#(
    parameter int GATE_CYCLES = GATE_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] inputPins,
    input wire logic runCmd,
    input wire logic runRev,
    input wire logic homeStart,
    input wire logic encA,
    input wire logic encB,
    input wire logic encZ,
    input wire logic pulseIn,
    input wire logic enterKey,
    input wire logic [2:0] slotSelect,
    output aps_drive_t drive,
    output logic [7:0] torqueFwd,
    output logic [7:0] torqueRev,
    output logic servoLock,
    output logic rangeTrip,
    output logic [15:0] pulseFreq
);
    // Synchronisers for pins
    // Bit map: inputPins 7..0, runCmd 8, runRev 9, homeStart 10, encA 11, encB 12,
    // encZ 13, pulseIn 14, enterKey 15
    logic [15:0] syn1_q, syn2_q, prev_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            syn1_q <= 16'h0000;
            syn2_q <= 16'h0000;
            prev_q <= 16'h0000;
        end else begin
            syn1_q <= {enterKey, pulseIn, encZ, encB, encA, homeStart, runRev, runCmd, inputPins};
            syn2_q <= syn1_q;
            prev_q <= syn2_q;
        end
    end
    wire [7:0] pins = syn2_q[7:0];
    wire runS = syn2_q[8];
    wire revS = syn2_q[9];
    wire homeGo = syn2_q[10] & ~prev_q[10];
    wire aS = syn2_q[11];
    wire bS = syn2_q[12];
    wire zRise = syn2_q[13] & ~prev_q[13];
    wire pulseRise = syn2_q[14] & ~prev_q[14];
    wire aChg = aS ^ prev_q[11];
    wire bChg = bS ^ prev_q[12];
    wire enterRise = syn2_q[15] & ~prev_q[15];

    // Register file
    logic [31:0] ctrl_q, assign_q, fwdLim_q, revLim_q, pulse_q, pbias_q;
    logic [31:0] slot_q [8];
    wire apbWr = psel & penable & pwrite;
    wire [1:0] homeMode = ctrl_q[1:0];
    wire homeRevDir = ctrl_q[2];
    wire [1:0] ctrlMode = ctrl_q[5:4];
    wire [2:0] charSel = ctrl_q[10:8];
    wire restartSel = ctrl_q[12];
    wire [15:0] scaleSet = pulse_q[15:0];
    wire [15:0] tcSet = pulse_q[31:16];
    wire [7:0] biasSet = pbias_q[7:0];
    wire [7:0] limSet = pbias_q[15:8];

    // Each input owns one nibble of assign_q; nibbles 5, 6 and D stand for servo-on,
    // excitation and teach, any other nibble n for code 0x40 + n (7..9 give 71..73)
    logic [6:0] fnCode [8];
    logic [3:0] fnNib [8];
    logic [7:0] isTeach, isServo, isExcite, isFwd, isRev, isSpd;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_fn
            assign fnNib[gi] = assign_q[gi*4 +: 4];
            assign fnCode[gi] =
                (fnNib[gi] == 4'h5) ? FN_SERVO :
                (fnNib[gi] == 4'h6) ? FN_EXCITE :
                (fnNib[gi] == 4'hD) ? FN_TEACH : {3'h4, fnNib[gi]};
            assign isTeach[gi] = pins[gi] & (fnCode[gi] == FN_TEACH);
            assign isServo[gi] = (fnCode[gi] == FN_SERVO);
            assign isExcite[gi] = (fnCode[gi] == FN_EXCITE);
            assign isFwd[gi] = pins[gi] & (fnCode[gi] == FN_FWDSTOP);
            assign isRev[gi] = pins[gi] & (fnCode[gi] == FN_REVSTOP);
            assign isSpd[gi] = pins[gi] & (fnCode[gi] == FN_SPDPOS);
        end
    endgenerate
    wire [7:0] servoPins = isServo & pins;
    wire servoAssigned = |isServo & ~|isExcite;
    wire servoOk = ~servoAssigned | |servoPins;
    wire spdOn = |isSpd;
    wire absMode = (ctrlMode == CM_ABS) | (ctrlMode == CM_HABS);
    wire teachOn = |isTeach & absMode;

    // Position counter and homing
    aps_home_t hs_q, hs_d;
    logic signed [31:0] pos_q;
    logic limWas_q, limSeen_q;
    logic [1:0] homeSel_q;
    wire homeLim = pins[0];
    wire quadStep = aChg ^ bChg;
    // High means reverse: B now differs from the old A, so B leads A
    wire quadDir = bS ^ prev_q[11];
    wire homeDone;
    always_comb begin
        hs_d = hs_q;
        case (hs_q)
            HS_IDLE: if (homeGo) hs_d = (homeMode == HM_LOW) ? HS_REVLOW : HS_FAST;
            HS_FAST: if (homeLim) hs_d = HS_DECEL;
            HS_DECEL: hs_d = HS_REVLOW;
            HS_REVLOW: begin
                if (homeSel_q == HM_LOW && homeLim) hs_d = HS_IDLE;
                else if (homeSel_q == HM_HIGH1 && !homeLim) hs_d = HS_IDLE;
                else if (homeSel_q == HM_HIGH2 && !homeLim) hs_d = HS_DECEL2;
            end
            HS_DECEL2: hs_d = HS_FWDLOW;
            HS_FWDLOW: if (homeLim) hs_d = HS_INDEX;
            HS_INDEX: if (zRise) hs_d = HS_IDLE;
            default: hs_d = HS_IDLE;
        endcase
    end
    assign homeDone = (hs_q != HS_IDLE) && (hs_d == HS_IDLE);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hs_q <= HS_IDLE;
            homeSel_q <= HM_LOW;
            pos_q <= 32'sh00000000;
        end else begin
            hs_q <= hs_d;
            if (hs_q == HS_IDLE) homeSel_q <= homeMode;
            if (spdOn || homeDone) pos_q <= 32'sh00000000;
            else if (quadStep) pos_q <= quadDir ? pos_q - 32'sh1 : pos_q + 32'sh1;
        end
    end

    // Position target and trips
    wire signed [31:0] target = $signed(slot_q[3'h0]);
    wire signed [31:0] diff = target - pos_q;
    wire overRange = (pos_q > $signed(fwdLim_q)) | (pos_q < $signed(revLim_q));
    logic trip_q, spdWas_q, servoWas_q, coastHold_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            trip_q <= 1'b0;
            spdWas_q <= 1'b0;
            servoWas_q <= 1'b1;
            coastHold_q <= 1'b0;
        end else begin
            if (overRange) trip_q <= 1'b1;
            else if (apbWr && paddr == A_STATUS && pwdata[0]) trip_q <= 1'b0;
            spdWas_q <= spdOn;
            servoWas_q <= servoOk;
            if (runS && servoWas_q && !servoOk) coastHold_q <= 1'b1;
            else if (servoOk && (restartSel || !runS)) coastHold_q <= 1'b0;
        end
    end

    // Drive command
    aps_drive_t drv_d;
    always_comb begin
        drv_d.run = runS & servoOk & ~trip_q & ~coastHold_q;
        drv_d.coast = trip_q | coastHold_q | (runS & ~servoOk);
        drv_d.speed = 2'h2;
        drv_d.dirRev = revS;
        if (hs_q != HS_IDLE) begin
            drv_d.run = ~trip_q;
            drv_d.speed = (hs_q == HS_FAST) ? 2'h3 : ((hs_q == HS_DECEL || hs_q == HS_DECEL2) ? 2'h0 : 2'h1);
            drv_d.dirRev = homeRevDir ^ ((hs_q == HS_REVLOW) && homeSel_q != HM_LOW);
        end else if (spdOn) begin
            drv_d.dirRev = revS;
        end else if (absMode && !teachOn) begin
            drv_d.dirRev = diff < 0;
            if (diff == 0) drv_d.run = 1'b0;
        end
    end
    wire lockNow = servoOk & |servoPins & (charSel == CC_SENSOR);

    // Teaching
    // Target slot is volatile: any reset brings it back to slot 0
    logic [2:0] teachSel_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            teachSel_q <= 3'h0;
        end else begin
            if (apbWr && pready && paddr == A_CTRL) teachSel_q <= pwdata[18:16];
        end
    end
    wire teachStore = teachOn & enterRise;

    // Pulse train: count rising edges in a gate window
    // Gate counter is full width: the default window is far beyond 16 bits
    logic [31:0] gate_q;
    logic [15:0] pcnt_q, praw_q;
    logic [31:0] filt_q;
    wire gateEnd = (gate_q == 32'(GATE_CYCLES - 1));
    wire [31:0] scaledW = (32'(praw_q) * 32'(FMAX_PCT100)) / (32'(scaleSet) == 0 ? 32'h1 : 32'(scaleSet));
    wire signed [31:0] filtStep = ($signed(scaledW) - $signed(filt_q)) / $signed(32'(tcSet) == 0 ? 32'h1 : 32'(tcSet));
    wire signed [31:0] biased = $signed(filt_q) + $signed({{24{biasSet[7]}}, biasSet}) * 32'sd100;
    wire signed [31:0] limW = 32'(limSet) * 32'd100;
    wire [15:0] pOut = (biased < 0) ? 16'h0000 : (biased > limW) ? limW[15:0] : biased[15:0];
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gate_q <= 32'h00000000;
            pcnt_q <= 16'h0000;
            praw_q <= 16'h0000;
            filt_q <= 32'h00000000;
        end else begin
            gate_q <= gateEnd ? 32'h00000000 : gate_q + 32'h1;
            if (gateEnd) begin
                praw_q <= pcnt_q;
                // An edge in the closing cycle opens the next window, so none is lost
                pcnt_q <= {15'h0000, pulseRise};
                filt_q <= filt_q + filtStep;
            end else if (pulseRise) begin
                pcnt_q <= pcnt_q + 16'h1;
            end
        end
    end

    // APB registers
    wire [31:0] rdMux =
        (paddr == A_CTRL) ? {13'h0, teachSel_q, ctrl_q[15:0]} :
        (paddr == A_ASSIGN) ? assign_q : (paddr == A_FWDLIM) ? fwdLim_q :
        (paddr == A_REVLIM) ? revLim_q : (paddr == A_PULSE) ? pulse_q :
        (paddr == A_PBIAS) ? pbias_q : (paddr == A_STATUS) ? {24'h0, hs_q, trip_q} :
        (paddr == A_POS) ? pos_q : (paddr == A_PFREQ) ? {16'h0, pulseFreq} :
        (paddr[7:5] == A_SLOT0[7:5]) ? slot_q[paddr[4:2]] : 32'h0;
    wire mapped = (paddr <= A_PFREQ || paddr[7:5] == A_SLOT0[7:5]) && paddr[1:0] == 2'h0;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= 32'h0;
            assign_q <= 32'h0;
            fwdLim_q <= FWDLIM_RST;
            revLim_q <= REVLIM_RST;
            pulse_q <= {TC_RST, SCALE_RST};
            pbias_q <= {16'h0, PLIM_RST, 8'h00};
            for (int i = 0; i < 8; i++) slot_q[i] <= 32'h0;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            if (psel && !penable) prdata <= rdMux;
            if (teachStore) slot_q[teachSel_q] <= pos_q;
            if (apbWr && pready && mapped) begin
                case (paddr)
                    A_CTRL: ctrl_q <= pwdata;
                    A_ASSIGN: assign_q <= pwdata;
                    A_FWDLIM: fwdLim_q <= pwdata;
                    A_REVLIM: revLim_q <= pwdata;
                    A_PULSE: pulse_q <= pwdata;
                    A_PBIAS: pbias_q <= pwdata;
                    default: if (paddr[7:5] == A_SLOT0[7:5]) slot_q[paddr[4:2]] <= pwdata;
                endcase
            end
        end
    end

    // Outputs
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            drive <= '0;
            torqueFwd <= TORQUE_FULL;
            torqueRev <= TORQUE_FULL;
            servoLock <= 1'b0;
            rangeTrip <= 1'b0;
            pulseFreq <= 16'h0;
        end else begin
            drive <= drv_d;
            torqueFwd <= |isFwd ? TORQUE_STOP : TORQUE_FULL;
            torqueRev <= |isRev ? TORQUE_STOP : TORQUE_FULL;
            servoLock <= lockNow;
            rangeTrip <= trip_q;
            pulseFreq <= pOut;
        end
    end
endmodule // aps_supervisor
`default_nettype wire

// ### aps_supervisor_chk.sv
`timescale 1ns/1ps
`default_nettype none
module aps_supervisor_chk
    import aps_pkg::*;
#(
    parameter int GATE_CYCLES = 20
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] inputPins,
    input wire aps_drive_t drive,
    input wire logic [7:0] torqueFwd,
    input wire logic [7:0] torqueRev,
    input wire logic rangeTrip
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [31:0] assignQ;
    logic [3:0] spdCnt;
    logic [7:0] fwdHit, revHit, spdHit;
    wire wrAcc = psel && penable && pready && pwrite;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            fwdHit[i] = assignQ[4*i+:4] == 4'h7;
            revHit[i] = assignQ[4*i+:4] == 4'h8;
            spdHit[i] = assignQ[4*i+:4] == 4'h9;
        end
    end
    wire fwdOn = |(fwdHit & inputPins);
    wire revOn = |(revHit & inputPins);
    wire spdOn = |(spdHit & inputPins);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            assignQ <= 32'h0;
            spdCnt <= 4'h0;
        end else begin
            assignQ <= (wrAcc && paddr == A_ASSIGN) ? pwdata : assignQ;
            spdCnt <= !spdOn ? 4'h0 : ((spdCnt == 4'hF) ? spdCnt : spdCnt + 4'h1);
        end
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_pos_read;
        s_setup ##0 (!pwrite && paddr == A_POS);
    endsequence
    a_ready_after_setup: assert property (s_setup |=> pready)
        else $error("no ready one cycle after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_err_unmapped: assert property (s_setup ##0 (paddr == 8'h30) |=> pready && pslverr)
        else $error("unmapped access not refused");
    a_ok_pos_read: assert property (s_pos_read |=> !pslverr)
        else $error("position read refused");
    a_fwd_stop_cut: assert property (fwdOn [*5] |-> torqueFwd == TORQUE_STOP)
        else $error("forward torque not cut");
    a_fwd_stop_free: assert property (!fwdOn [*5] |-> torqueFwd == TORQUE_FULL)
        else $error("forward torque cut without stop");
    a_rev_stop_cut: assert property (revOn [*5] |-> torqueRev == TORQUE_STOP)
        else $error("reverse torque not cut");
    a_rev_stop_free: assert property (!revOn [*5] |-> torqueRev == TORQUE_FULL)
        else $error("reverse torque cut without stop");
    a_trip_coasts: assert property (rangeTrip |-> ##[0:2] drive.coast)
        else $error("range trip without coasting");
    a_spd_pos_zero: assert property (spdCnt == 4'hF ##0 s_pos_read |=> prdata == 32'h0)
        else $error("position not held at zero");
endmodule // aps_supervisor_chk
`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import aps_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, inputPins = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic pready, pslverr, rerr, encA, encB, encZ, enterKey = 1'b0;
    logic stepFwd = 1'b0, stepRev = 1'b0, servoLock, rangeTrip;
    logic runCmd = 1'b0, pulseIn = 1'b0, pulseOn = 1'b0;
    aps_drive_t drive;
    logic [7:0] torqueFwd, torqueRev;
    logic [15:0] pulseFreq;
    int fails = 0, n_compared = 0;
    always #25 clk = ~clk;
    // Pulse train at half the clock rate while enabled
    always @(posedge clk) pulseIn <= pulseOn & ~pulseIn;
    aps_supervisor #(.GATE_CYCLES(20)) dut (.clk(clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .inputPins(inputPins), .runCmd(runCmd),
        .runRev(1'b0), .homeStart(1'b0), .encA(encA), .encB(encB), .encZ(encZ),
        .pulseIn(pulseIn), .enterKey(enterKey), .slotSelect(3'h0), .drive(drive),
        .torqueFwd(torqueFwd), .torqueRev(torqueRev), .servoLock(servoLock),
        .rangeTrip(rangeTrip), .pulseFreq(pulseFreq));
    aps_machine machine (.clk(clk), .rstn(rstn), .stepFwd(stepFwd), .stepRev(stepRev),
        .encA(encA), .encB(encB), .encZ(encZ));
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        if (n >= 20) begin
            fails++;
            finish_test();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdata, exp);
    endtask
    task automatic mv(input int k, input logic rev);
        repeat (k) begin
            stepFwd <= !rev;
            stepRev <= rev;
            @(posedge clk);
            stepFwd <= 1'b0;
            stepRev <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask
    initial begin
        int n;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(A_CTRL, 32'h0);
        rd(A_FWDLIM, FWDLIM_RST);
        rd(A_REVLIM, REVLIM_RST);
        rd(A_PULSE, {TC_RST, SCALE_RST});
        rd(A_PBIAS, {16'h0, PLIM_RST, 8'h00});
        chk({24'h0, torqueFwd}, {24'h0, TORQUE_FULL});
        rd(8'h30, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        apb(1'b1, A_ASSIGN, 32'h000D9870);
        mv(12, 1'b0);
        mv(5, 1'b1);
        rd(A_POS, 32'h7);
        inputPins <= 8'h08;
        repeat (8) @(posedge clk);
        rd(A_POS, 32'h0);
        mv(3, 1'b0);
        rd(A_POS, 32'h0);
        inputPins <= 8'h10;
        repeat (8) @(posedge clk);
        mv(2, 1'b0);
        rd(A_POS, 32'h2);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, A_CTRL, {13'h0, i[2:0], 10'h0, CM_ABS, 4'h0});
            mv(1, 1'b0);
            enterKey <= 1'b1;
            repeat (4) @(posedge clk);
            enterKey <= 1'b0;
            repeat (4) @(posedge clk);
            rd(A_SLOT0 + 8'(4 * i), 32'(3 + i));
        end
        apb(1'b1, A_FWDLIM, 32'hC);
        mv(3, 1'b0);
        n = 0;
        while (rangeTrip !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n >= 50) begin
            fails++;
            finish_test();
        end
        repeat (3) @(posedge clk);
        chk({31'h0, rangeTrip}, 32'h1);
        chk({31'h0, drive.coast}, 32'h1);
        rd(A_STATUS, {24'h0, HS_IDLE, 1'b1});
        apb(1'b1, A_FWDLIM, FWDLIM_RST);
        apb(1'b1, A_STATUS, 32'h1);
        rd(A_STATUS, {24'h0, HS_IDLE, 1'b0});
        inputPins <= 8'h02;
        repeat (6) @(posedge clk);
        chk({16'h0, torqueFwd, torqueRev}, {16'h0, TORQUE_STOP, TORQUE_FULL});
        inputPins <= 8'h04;
        repeat (6) @(posedge clk);
        chk({16'h0, torqueFwd, torqueRev}, {16'h0, TORQUE_FULL, TORQUE_STOP});
        inputPins <= 8'h00;
        // Scale 10 and time constant 1: ten pulses per window give full frequency
        apb(1'b1, A_PULSE, 32'h0001000A);
        pulseOn <= 1'b1;
        repeat (100) @(posedge clk);
        chk({16'h0, pulseFreq}, {16'h0, FMAX_PCT100});
        apb(1'b1, A_PBIAS, {16'h0, PLIM_RST, 8'hF6});
        repeat (3) @(posedge clk);
        chk({16'h0, pulseFreq}, 32'h00002328);
        apb(1'b1, A_PBIAS, 32'h00003200);
        repeat (3) @(posedge clk);
        chk({16'h0, pulseFreq}, 32'h00001388);
        pulseOn <= 1'b0;
        // Servo-on on input 5, sensor vector control, teach slot 7
        apb(1'b1, A_ASSIGN, 32'h005D9870);
        apb(1'b1, A_CTRL, {13'h0, 3'h7, 5'h0, CC_SENSOR, 8'h00});
        rd(A_CTRL, {13'h0, 3'h7, 5'h0, CC_SENSOR, 8'h00});
        runCmd <= 1'b1;
        repeat (6) @(posedge clk);
        chk({31'h0, drive.run}, 32'h0);
        inputPins <= 8'h20;
        repeat (6) @(posedge clk);
        chk({31'h0, servoLock}, 32'h1);
        chk({31'h0, drive.run}, 32'h1);
        inputPins <= 8'h00;
        repeat (6) @(posedge clk);
        chk({31'h0, drive.coast}, 32'h1);
        inputPins <= 8'h20;
        repeat (6) @(posedge clk);
        chk({31'h0, drive.run}, 32'h0);
        runCmd <= 1'b0;
        inputPins <= 8'h00;
        // Reset after the run command is dropped must bring the teach target back to slot 0
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(A_CTRL, 32'h0);
        chk({24'h0, torqueRev}, {24'h0, TORQUE_FULL});
        finish_test();
    end
endmodule // testbench
bind aps_supervisor aps_supervisor_chk #(.GATE_CYCLES(GATE_CYCLES)) chk (.*);
`default_nettype wire
